// file: pkg/xmi_map.svh
// Contract
// - four wait settings exist, the lowest adds no wait state
// - external space splits into two sectors with own wait settings
// - legacy mode allows only upper wait codes 00 and 01
// - legacy mode: fixed high bits, no split, no keeper, strobes output only
// - shared low address/data byte, high address bus, latch, read, write strobes
// - enabled interface overrides port direction settings on its pins
// - address decides internal or external; external drives pins and strobes
// - low address valid at latch fall; latch low through the data phase (here the low address leaves the bus on the edge where latch falls)
// - internal access may show bus activity but never read/write strobes
// - disabled interface restores port pins; no aliasing above internal sram
// - port output ones enable pull-ups on shared address/data pins
// - bus keeper holds last driven value while drivers are off
// - trailing latch pulse in final period only if next access hits ram
// - upper sector uses upper wait pair, lower sector the lower pair
// - software selects how many high address bits are driven
// - legacy mode makes extended control registers inaccessible, features off
// - wait codes: 00 none, 01 one, 10 two, 11 two plus address hold cycle
// - pin functions active only while the enable bit is one
// - three-bit sector limit; code zero makes 0x1100-0xffff one upper sector
// - three-bit high mask; code zero keeps 8 bits, each step releases one
`ifndef XMI_MAP_SVH
`define XMI_MAP_SVH
`define XMI_OFF_CORE_CTRL 32'h0000_0000
`define XMI_OFF_CTRL_A 32'h0000_0004
`define XMI_OFF_CTRL_B 32'h0000_0008
`define XMI_OFF_STATUS 32'h0000_000c
`define XMI_OFF_PORT_AD 32'h0000_0010
`define XMI_OFF_RDDATA 32'h0000_0014
`define XMI_CORE_ENABLE_BIT 7
`define XMI_CORE_UWLO_BIT 6
`define XMI_CORE_RESET 8'h00
`define XMI_CTRLA_MASK 8'h7e
`define XMI_CTRLA_SRL_LSB 4
`define XMI_CTRLA_LWAIT_LSB 2
`define XMI_CTRLA_UWHI_BIT 1
`define XMI_CTRLB_MASK 8'h87
`define XMI_CTRLB_KEEP_BIT 7
`define XMI_CTRLA_RESET 8'h00
`define XMI_CTRLB_RESET 8'h00
`define XMI_EXT_BASE 16'h1100
`endif

// file: pkg/xmi_pkg.sv
package xmi_pkg;
    typedef enum logic [2:0] {
        XMI_IDLE = 3'b000,
        XMI_ADDR = 3'b001,
        XMI_STRB = 3'b010,
        XMI_WAIT = 3'b011,
        XMI_LAST = 3'b100,
        XMI_HOLD = 3'b101
    } xmi_state_e;
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic write;
        logic next_ram;
    } xmi_req_s;
    typedef struct packed {
        logic [7:0] ad_out;
        logic [7:0] ad_oe;
        logic [7:0] ad_pullup;
        logic [7:0] hi_addr;
        logic [7:0] hi_oe;
        logic ale;
        logic rd_n;
        logic wr_n;
        logic strobe_oe;
    } xmi_pins_s;
endpackage

// file: src/xmi_sector.sv
`timescale 1ns/1ps
`default_nettype none
`include "xmi_map.svh"
module xmi_sector
    import xmi_pkg::*;
(
    // address and setup
    input wire logic [15:0] addr,
    input wire logic [2:0] limit_code,
    input wire logic [1:0] upper_wait_code,
    input wire logic [1:0] lower_wait_code,
    input wire logic legacy,
    // decode
    output logic external,
    output logic [1:0] wait_code
);
    logic [15:0] bound;
    logic upper;
    // limit steps through 0x2000, 0x4000 ... 0xe000
    assign bound = {limit_code, 13'h0000};
    assign external = addr >= `XMI_EXT_BASE;
    assign upper = legacy || limit_code == 3'b000 || addr >= bound;
    // legacy keeps only the low upper bit meaningful
    assign wait_code = upper ? (legacy ? {1'b0, upper_wait_code[0]} : upper_wait_code)
                             : lower_wait_code;
endmodule // xmi_sector
`default_nettype wire

// file: src/xmi_ext_bus_unit.sv
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "xmi_map.svh"
module xmi_ext_bus_unit
    import xmi_pkg::*;
(
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // legacy strap
    input wire logic LEGACY_MODE,
    // cpu data access
    input wire logic REQ_VALID,
    input wire xmi_pkg::xmi_req_s REQ,
    output logic REQ_READY,
    output logic RD_VALID,
    output logic [7:0] RD_DATA,
    // pins
    input wire logic [7:0] AD_IN,
    output xmi_pkg::xmi_pins_s PINS,
    output logic BUS_KEEP
);
    import xmi_pkg::*;

    xmi_state_e st_q, st_d;
    logic [7:0] core_q, ctrl_a_q, ctrl_b_q, port_q;
    logic [15:0] addr_q;
    logic [7:0] wdata_q, rd_q, hi_q, ad_q;
    logic write_q, nram_q, ext_q, rdv_q, ale_q, rd_n_q, wr_n_q, ad_oe_q, hi_oe_q;
    logic [1:0] wait_q, cnt_q;
    logic en, legacy, ext, wr_phase, rd_en, rd_phase, last_phase;
    logic [1:0] wcode;
    logic [2:0] limit, mask;
    logic [7:0] hi_drive;
    logic apb_wr, apb_rd, hit_core, hit_a, hit_b, hit_port, hit_stat, hit_rd, mapped;

    function automatic logic sel(input logic [31:0] a, input logic [31:0] off);
        sel = a[7:0] == off[7:0] && a[31:8] == 24'h000000;
    endfunction

    assign legacy = LEGACY_MODE;
    assign en = core_q[`XMI_CORE_ENABLE_BIT];
    // extended registers read as zero with a slave error and do nothing in legacy mode
    assign limit = legacy ? 3'b000 : ctrl_a_q[`XMI_CTRLA_SRL_LSB +: 3];
    assign mask = legacy ? 3'b000 : ctrl_b_q[2:0];

    xmi_sector u_sector (
        .addr(REQ.addr),
        .limit_code(limit),
        .upper_wait_code({ctrl_a_q[`XMI_CTRLA_UWHI_BIT], core_q[`XMI_CORE_UWLO_BIT]}),
        .lower_wait_code(ctrl_a_q[`XMI_CTRLA_LWAIT_LSB +: 2]),
        .legacy(legacy),
        .external(ext),
        .wait_code(wcode)
    );

    // apb decode
    assign apb_wr = PSEL && PENABLE && PWRITE;
    assign apb_rd = PSEL && !PWRITE;
    assign hit_core = sel(PADDR, `XMI_OFF_CORE_CTRL);
    assign hit_a = sel(PADDR, `XMI_OFF_CTRL_A) && !legacy;
    assign hit_b = sel(PADDR, `XMI_OFF_CTRL_B) && !legacy;
    assign hit_stat = sel(PADDR, `XMI_OFF_STATUS);
    assign hit_port = sel(PADDR, `XMI_OFF_PORT_AD);
    assign hit_rd = sel(PADDR, `XMI_OFF_RDDATA);
    assign mapped = hit_core | hit_a | hit_b | hit_stat | hit_port | hit_rd;
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !mapped;
    always_comb
    begin
        PRDATA = 32'h0000_0000;
        if (apb_rd && hit_core)
            PRDATA = {24'h000000, core_q};
        else if (apb_rd && hit_a)
            PRDATA = {24'h000000, ctrl_a_q};
        else if (apb_rd && hit_b)
            PRDATA = {24'h000000, ctrl_b_q};
        else if (apb_rd && hit_stat)
            PRDATA = {29'h00000000, legacy, ext_q, (st_q != XMI_IDLE)};
        else if (apb_rd && hit_port)
            PRDATA = {24'h000000, port_q};
        else if (apb_rd && hit_rd)
            PRDATA = {24'h000000, rd_q};
    end

    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            core_q <= `XMI_CORE_RESET;
            ctrl_a_q <= `XMI_CTRLA_RESET;
            ctrl_b_q <= `XMI_CTRLB_RESET;
            port_q <= 8'h00;
        end
        else if (apb_wr)
        begin
            if (hit_core)
                core_q <= PWDATA[7:0];
            if (hit_a)
                ctrl_a_q <= PWDATA[7:0] & `XMI_CTRLA_MASK;
            if (hit_b)
                ctrl_b_q <= PWDATA[7:0] & `XMI_CTRLB_MASK;
            if (hit_port)
                port_q <= PWDATA[7:0];
        end
    end

    // access sequencer: addr (ale high), strobe, waits, last period, optional hold
    assign REQ_READY = st_q == XMI_IDLE;
    assign last_phase = st_q == XMI_LAST;
    always_comb
    begin
        st_d = st_q;
        case (st_q)
            XMI_IDLE: if (REQ_VALID) st_d = XMI_ADDR;
            XMI_ADDR: st_d = XMI_STRB;
            XMI_STRB: st_d = (ext_q && wait_q != 2'b00) ? XMI_WAIT : XMI_LAST;
            XMI_WAIT: st_d = (cnt_q == 2'b00) ? XMI_LAST : XMI_WAIT;
            XMI_LAST: st_d = (ext_q && wait_q == 2'b11) ? XMI_HOLD : XMI_IDLE;
            XMI_HOLD: st_d = XMI_IDLE;
            default: st_d = XMI_IDLE;
        endcase
    end

    assign wr_phase = st_q == XMI_STRB || st_q == XMI_WAIT;
    // strobes only for external accesses with the interface on
    assign rd_en = en && ext_q;
    assign rd_phase = wr_phase && rd_en && !write_q;
    // each step of the mask code frees one more top pin
    assign hi_drive = 8'hff >> mask;

    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            st_q <= XMI_IDLE;
            addr_q <= 16'h0000;
            wdata_q <= 8'h00;
            write_q <= 1'b0;
            nram_q <= 1'b0;
            ext_q <= 1'b0;
            wait_q <= 2'b00;
            cnt_q <= 2'b00;
        end
        else
        begin
            st_q <= st_d;
            if (st_q == XMI_IDLE && REQ_VALID)
            begin
                addr_q <= REQ.addr;
                wdata_q <= REQ.wdata;
                write_q <= REQ.write;
                nram_q <= REQ.next_ram;
                ext_q <= ext;
                wait_q <= wcode;
                // 01 one wait cycle, 10 and 11 two
                cnt_q <= (wcode == 2'b01) ? 2'b00 : 2'b01;
            end
            else if (st_q == XMI_WAIT)
                cnt_q <= cnt_q - 2'b01;
        end
    end

    // registered pin drive
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            ale_q <= 1'b0;
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
            ad_oe_q <= 1'b0;
            hi_oe_q <= 1'b0;
            ad_q <= 8'h00;
            hi_q <= 8'h00;
            rd_q <= 8'h00;
            rdv_q <= 1'b0;
        end
        else
        begin
            rdv_q <= 1'b0;
            // latch high with the address, falls on the same edge where the address leaves the bus
            ale_q <= en && (st_d == XMI_ADDR ||
                    (st_d == XMI_LAST && nram_q));
            hi_oe_q <= en;
            if (st_d == XMI_ADDR && en)
            begin
                ad_q <= REQ.addr[7:0];
                hi_q <= REQ.addr[15:8];
                ad_oe_q <= 1'b1;
            end
            else if (st_d == XMI_STRB && en)
            begin
                ad_q <= wdata_q;
                ad_oe_q <= write_q;
            end
            else if (st_q == XMI_LAST || st_q == XMI_HOLD || !en)
                ad_oe_q <= 1'b0;
            wr_n_q <= !(rd_en && write_q && (st_d == XMI_STRB || st_d == XMI_WAIT));
            rd_n_q <= !(rd_en && !write_q && (st_d == XMI_STRB || st_d == XMI_WAIT));
            // sample on the edge where the read strobe rises
            if (rd_phase && (st_d == XMI_LAST))
            begin
                rd_q <= AD_IN;
                rdv_q <= 1'b1;
            end
            else if (!write_q && !rd_en && st_q == XMI_STRB)
                rdv_q <= 1'b1;
        end
    end

    assign RD_VALID = rdv_q;
    assign RD_DATA = rd_q;
    // keeper works regardless of enable, but never in legacy mode
    assign BUS_KEEP = !legacy && ctrl_b_q[`XMI_CTRLB_KEEP_BIT];
    assign PINS.ad_out = ad_q;
    assign PINS.ad_oe = {8{ad_oe_q && en}};
    assign PINS.ad_pullup = (en && !ad_oe_q) ? port_q : 8'h00;
    assign PINS.hi_addr = hi_q & hi_drive;
    assign PINS.hi_oe = {8{hi_oe_q && en}} & hi_drive;
    assign PINS.ale = ale_q;
    assign PINS.rd_n = rd_n_q;
    assign PINS.wr_n = wr_n_q;
    assign PINS.strobe_oe = en;
    // unused registered address, last phase flag and upper write data bits are harmless here
    logic unused_ok;
    assign unused_ok = ^{addr_q, last_phase, PWDATA[31:8]};
endmodule // xmi_ext_bus_unit
`default_nettype wire

// file: testbench/xmi_ext_bus_unit_chk.sv
`timescale 1ns/1ps
`default_nettype none
module xmi_chk
    import xmi_pkg::*;
(
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // request side
    input wire logic REQ_VALID,
    input wire xmi_pkg::xmi_req_s REQ,
    input wire logic REQ_READY,
    // pins
    input wire xmi_pkg::xmi_pins_s PINS
);
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RST_N);
    logic nr_q;
    wire logic take = REQ_VALID && REQ_READY;
    wire logic ext = REQ.addr >= 16'h1100;
    // the request may change right after it is taken, so keep its tail flag
    always_ff @(posedge REF_CLK or negedge RST_N)
        if (!RST_N)
            nr_q <= 1'b0;
        else if (take)
            nr_q <= REQ.next_ram;
    property p_int;
        take && !ext |=> (PINS.rd_n && PINS.wr_n)[*4];
    endproperty
    a_int: assert property (p_int) else $error("strobe on internal access");
    property p_ale;
        take && ext && PINS.strobe_oe |=> PINS.ale && PINS.ad_out == $past(REQ.addr[7:0])
            ##1 !PINS.ale;
    endproperty
    a_ale: assert property (p_ale) else $error("address phase wrong");
    property p_rw;
        !(!PINS.rd_n && !PINS.wr_n);
    endproperty
    a_rw: assert property (p_rw) else $error("both strobes low");
    property p_len;
        $fell(PINS.rd_n) |-> ##[1:3] PINS.rd_n;
    endproperty
    a_len: assert property (p_len) else $error("read strobe too long");
    property p_rdz;
        !PINS.rd_n |-> PINS.ad_oe == 8'h00;
    endproperty
    a_rdz: assert property (p_rdz) else $error("bus driven during read");
    property p_wd;
        !PINS.wr_n && !$past(PINS.wr_n) |-> PINS.ad_oe == 8'hff && $stable(PINS.ad_out);
    endproperty
    a_wd: assert property (p_wd) else $error("write data not held");
    property p_tail;
        $rose(PINS.wr_n) || $rose(PINS.rd_n) |-> PINS.ale == nr_q;
    endproperty
    a_tail: assert property (p_tail) else $error("tail latch pulse wrong");
    property p_off;
        !PINS.strobe_oe |-> PINS.ad_oe == 8'h00 && PINS.hi_oe == 8'h00;
    endproperty
    a_off: assert property (p_off) else $error("pins driven while off");
endmodule // xmi_chk
bind xmi_ext_bus_unit xmi_chk u_chk (.REF_CLK, .RST_N, .REQ_VALID, .REQ, .REQ_READY, .PINS);
`default_nettype wire

// file: testbench/xmi_sram_model.sv
`timescale 1ns/1ps
`default_nettype none
module xmi_sram_model
    import xmi_pkg::*;
(
    // clock and bus
    input wire logic clk,
    input wire logic slow,
    input wire logic [7:0] ad,
    input wire xmi_pkg::xmi_pins_s pins,
    // read drive
    output logic [7:0] dout,
    output logic doe
);
    logic [7:0] mem [0:65535];
    logic [7:0] lat;
    logic rd_q;
    wire logic [15:0] addr = {pins.hi_addr & pins.hi_oe, lat};
    always_latch
        if (pins.ale)
            lat <= ad;
    // mid-cycle sampling keeps clear of the edge where the bus is released
    always @(negedge clk)
        if (!pins.wr_n)
            mem[addr] <= ad;
    always @(posedge clk)
        rd_q <= pins.rd_n;
    // a slow part shows garbage in the first strobe cycle
    assign doe = !pins.rd_n;
    assign dout = (slow && rd_q) ? ~mem[addr] : mem[addr];
endmodule // xmi_sram_model
`default_nettype wire

// file: testbench/test_external_memory_interface.sv
`timescale 1ns/1ps
`default_nettype none
`include "xmi_map.svh"
module test_external_memory_interface;
    import xmi_pkg::*;
    logic REF_CLK = 1'b0, RST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic LEGACY_MODE = 1'b0, REQ_VALID = 1'b0, slow = 1'b0;
    logic [31:0] PADDR = 32'h0, PWDATA = 32'h0, PRDATA;
    logic PREADY, PSLVERR, REQ_READY, RD_VALID, BUS_KEEP, doe;
    logic [7:0] RD_DATA, dout, last_q;
    xmi_req_s REQ = '0;
    xmi_pins_s PINS;
    wire logic [7:0] ad_w;
    int error_cnt = 0;
    int n_tests = 0;
    int rv_seen = 0;
    // released lines: keeper holds, pull-up lifts, otherwise they drift
    assign ad_w = (PINS.ad_oe & PINS.ad_out) | (~PINS.ad_oe & (doe ? dout
        : BUS_KEEP ? last_q : PINS.ad_pullup | ~last_q));
    always @(posedge REF_CLK)
        last_q <= ad_w;
    xmi_ext_bus_unit uut (.REF_CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
        .PRDATA, .PREADY, .PSLVERR, .LEGACY_MODE, .REQ_VALID, .REQ, .REQ_READY,
        .RD_VALID, .RD_DATA, .AD_IN(ad_w), .PINS, .BUS_KEEP);
    xmi_sram_model mdl (.clk(REF_CLK), .slow, .ad(ad_w), .pins(PINS), .dout, .doe);
    initial
        forever #20 REF_CLK = ~REF_CLK;
    task automatic conclude();
        $display("tests %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic hang();
        error_cnt++;
        conclude();
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %s exp %h got %h", what, exp, got);
        end
    endtask
    function automatic int nl(input logic [1:0] c);
        return (c == 2'b00) ? 1 : (c == 2'b01) ? 2 : 3;
    endfunction
    task automatic apb(input logic w, input logic [31:0] a, d, output logic [31:0] r,
        output logic e);
        @(posedge REF_CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        r = 32'h0;
        e = 1'b0;
        repeat (9)
        begin
            @(posedge REF_CLK);
            if (PREADY === 1'b1)
            begin
                r = PRDATA;
                e = PSLVERR;
                break;
            end
        end
        if (PREADY !== 1'b1)
            hang();
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d,
        input logic nr, output int lo, output logic [7:0] hioe);
        hioe = 8'h00;
        lo = 0;
        rv_seen = 0;
        @(posedge REF_CLK);
        REQ_VALID <= 1'b1;
        REQ <= '{addr: a, wdata: d, write: w, next_ram: nr};
        @(negedge REF_CLK);
        if (REQ_READY !== 1'b1)
            hang();
        @(posedge REF_CLK);
        REQ_VALID <= 1'b0;
        repeat (20)
        begin
            @(negedge REF_CLK);
            if (PINS.ale && lo == 0)
                hioe = PINS.hi_oe;
            if (!PINS.rd_n || !PINS.wr_n)
                lo++;
            if (RD_VALID === 1'b1)
                rv_seen++;
            if (REQ_READY === 1'b1)
                break;
        end
        if (REQ_READY !== 1'b1)
            hang();
    endtask
    initial
    begin
        logic [31:0] r;
        logic e;
        logic [15:0] a;
        logic [7:0] d, ho;
        int lo;
        void'($urandom(32'hdb93a771));
        repeat (6) @(posedge REF_CLK);
        RST_N <= 1'b1;
        apb(1'b0, `XMI_OFF_CORE_CTRL, 32'h0, r, e);
        chk("core_ctrl", `XMI_CORE_RESET, r);
        apb(1'b0, `XMI_OFF_CTRL_A, 32'h0, r, e);
        chk("ctrl_a", `XMI_CTRLA_RESET, r);
        apb(1'b0, 32'h20, 32'h0, r, e);
        chk("unmapped", 1, e);
        for (int c = 0; c < 4; c++)
        begin
            apb(1'b1, `XMI_OFF_CORE_CTRL, {24'h0, 1'b1, c[0], 6'h0}, r, e);
            apb(1'b1, `XMI_OFF_CTRL_A, {30'h0, c[1], 1'b0}, r, e);
            a = 16'h1100 + 16'($urandom % 32'heeff);
            d = 8'($urandom);
            slow <= (c != 0);
            acc(1'b1, a, d, 1'($urandom), lo, ho);
            chk("wr_len", nl(2'(c)), lo);
            chk("hi_oe", 8'hff, ho);
            chk("wr_valid", 0, rv_seen);
            acc(1'b0, a, 8'h00, 1'($urandom), lo, ho);
            chk("rd_len", nl(2'(c)), lo);
            chk("rd_data", d, RD_DATA);
            chk("rd_valid", 1, rv_seen);
        end
        apb(1'b1, `XMI_OFF_CORE_CTRL, 32'h80, r, e);
        apb(1'b1, `XMI_OFF_CTRL_A, 32'h16, r, e);
        acc(1'b1, 16'h1fff, 8'h5a, 1'b0, lo, ho);
        chk("lower_len", 2, lo);
        acc(1'b1, 16'h2000, 8'ha5, 1'b1, lo, ho);
        chk("upper_len", 3, lo);
        acc(1'b0, 16'h10ff, 8'h00, 1'b0, lo, ho);
        chk("internal_len", 0, lo);
        chk("internal_valid", 1, rv_seen);
        apb(1'b1, `XMI_OFF_CTRL_B, 32'h83, r, e);
        apb(1'b1, `XMI_OFF_PORT_AD, 32'ha5, r, e);
        acc(1'b1, 16'hff00, 8'h3c, 1'b0, lo, ho);
        chk("hi_mask", 8'h1f, ho);
        chk("keeper", 1, BUS_KEEP);
        chk("pullup", 8'ha5, PINS.ad_pullup);
        apb(1'b1, `XMI_OFF_CORE_CTRL, 32'hc0, r, e);
        LEGACY_MODE <= 1'b1;
        apb(1'b0, `XMI_OFF_CTRL_A, 32'h0, r, e);
        chk("legacy_ctrl_a", 1, e);
        acc(1'b1, 16'h1200, 8'h77, 1'b0, lo, ho);
        chk("legacy_len", 2, lo);
        chk("legacy_keep", 0, BUS_KEEP);
        apb(1'b1, `XMI_OFF_CORE_CTRL, 32'h00, r, e);
        acc(1'b1, 16'h4000, 8'h11, 1'b0, lo, ho);
        chk("off_len", 0, lo);
        conclude();
    end
    initial
    begin
        repeat (20000) @(posedge REF_CLK);
        hang();
    end
endmodule // test_external_memory_interface
`default_nettype wire
